//--- logic/dfc_pkg.sv
// constants for the downconverter and frame configuration block
`default_nettype none
package dfc_pkg;
    localparam int        DFC_AW       = 12;
    localparam int        DFC_SW       = 14;
    localparam int        DFC_OW       = 18;
    localparam int        DFC_WW       = DFC_OW + 1;
    // register indices, byte address is four times the index
    localparam bit [7:0]  IDX_PAT_LO   = 8'h20;
    localparam bit [7:0]  IDX_PAT_MID  = 8'h21;
    localparam bit [7:0]  IDX_PAT_HI   = 8'h22;
    localparam bit [7:0]  IDX_FEAT     = 8'h24;
    localparam bit [7:0]  IDX_DEC      = 8'h25;
    localparam bit [7:0]  IDX_MIX      = 8'h26;
    // writable bits, reserved bits store and read zero
    localparam bit [7:0]  PATHI_WMASK  = 8'h0f;
    localparam bit [7:0]  FEAT_WMASK   = 8'h1e;
    localparam bit [7:0]  DEC_WMASK    = 8'hf9;
    localparam bit [7:0]  MIX_WMASK    = 8'hff;
    localparam bit [7:0]  RST_BYTE     = 8'h00;
    localparam bit [19:0] RST_PAT      = 20'h00000;
    // feature path control fields
    localparam int        FEAT_ROUTE_L = 3;
    localparam int        FEAT_PATH    = 2;
    localparam int        FEAT_DEC_EN  = 1;
    localparam bit [1:0]  ROUTE_A_ONLY = 2'h0;
    localparam bit [1:0]  ROUTE_A_B    = 2'h1;
    // decimation control fields
    localparam int        DEC_ROUTE_EN = 7;
    localparam int        DEC_RATIO_L  = 4;
    localparam int        DEC_REAL     = 3;
    localparam int        DEC_PHASE    = 0;
    localparam bit [2:0]  RATIO_BYPASS = 3'h0;
    localparam bit [2:0]  RATIO_MAX    = 3'h5;
    // mixer control fields
    localparam int        MIX_GAIN_A_L = 6;
    localparam int        MIX_RELOAD_A = 5;
    localparam int        MIX_QRM_A    = 4;
    localparam int        MIX_GAIN_B_L = 2;
    localparam int        MIX_RELOAD_B = 1;
    localparam int        MIX_QRM_B    = 0;
    localparam bit [1:0]  GAIN_0DB     = 2'h0;
    localparam bit [1:0]  GAIN_3DB     = 2'h1;
    localparam bit [1:0]  GAIN_6DB     = 2'h2;
    // output resolution codes and their automatic frame patterns
    localparam bit [1:0]  RES_14       = 2'h0;
    localparam bit [1:0]  RES_16       = 2'h1;
    localparam bit [1:0]  RES_18       = 2'h2;
    localparam bit [1:0]  RES_20       = 2'h3;
    localparam bit [19:0] AUTO_PAT_14  = 20'hfe000;
    localparam bit [19:0] AUTO_PAT_16  = 20'hff000;
    localparam bit [19:0] AUTO_PAT_18  = 20'hff800;
    localparam bit [19:0] AUTO_PAT_20  = 20'hffc00;
endpackage
`default_nettype wire

//--- logic/dfc_top.sv
// register file, routing and decimating sample path of the downconverter block
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - 20-bit frame duty pattern in three byte registers, low byte first, RW
// - decimation bypassed: frame pattern chosen automatically from output resolution
// - route 00 feeds downconverter A only, 01 feeds A and B
// - routing field acts only while route enable bit is set
// - feature path bit clear bypasses feature block, set passes through
// - one decimator enable bit switches filtering for both channels
// - ratio 000 no decimation, 001..101 decimate by 2..32
// - real bit selects low-pass only, clear selects complex decimation
// - phase bit inverts the oscillator phase used for mixing
// - per-channel gain code adds 0, 3 or 6 dB after mixer
// - toggling a restart bit restarts that channel; bit not self-clearing
//////////////////////////////////////////////////////////////////////////////
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dfc_top (
    // clock and reset
    input  wire logic                      clk_sys_in,
    input  wire logic                      rst_b_in,
    // apb slave
    input  wire logic                      psel_in,
    input  wire logic                      penable_in,
    input  wire logic                      pwrite_in,
    input  wire logic [dfc_pkg::DFC_AW-1:0] paddr_in,
    input  wire logic [31:0]               pwdata_in,
    input  wire logic [3:0]                pstrb_in,
    output logic                           pready_out,
    output logic      [31:0]               prdata_out,
    output logic                           pslverr_out,
    // converter channel a samples
    input  wire logic [dfc_pkg::DFC_SW-1:0] sample_in,
    input  wire logic                      sample_valid_in,
    output logic                           sample_ready_out,
    input  wire logic [1:0]                resolution_in,
    // processed sample stream
    output logic      [dfc_pkg::DFC_WW-1:0] word_out,
    output logic                           word_valid_out,
    input  wire logic                      word_ready_in,
    // configuration seen by the serializer and mixers
    output logic      [19:0]               frame_duty_pattern_out,
    output logic                           route_to_b_out,
    output logic                           decimator_enable_out,
    output logic      [2:0]                ratio_out,
    output logic                           real_mode_out,
    output logic                           phase_invert_out,
    output logic      [1:0]                gain_a_out,
    output logic      [1:0]                gain_b_out,
    output logic                           quarter_rate_mix_a_out,
    output logic                           quarter_rate_mix_b_out,
    output logic                           mixer_restart_a_out,
    output logic                           mixer_restart_b_out
);
    import dfc_pkg::*;

    function automatic logic [4:0] dfc_ratio_mask(input logic [2:0] r);
        logic [4:0] m;
        m = 5'h00;
        if (r <= RATIO_MAX && r != RATIO_BYPASS) begin
            m = 5'((6'h01 << r) - 6'h01);
        end
        return m;
    endfunction

    function automatic logic [19:0] dfc_auto_pattern(input logic [1:0] res);
        logic [19:0] p;
        p = AUTO_PAT_20;
        if (res == RES_14) begin
            p = AUTO_PAT_14;
        end else if (res == RES_16) begin
            p = AUTO_PAT_16;
        end else if (res == RES_18) begin
            p = AUTO_PAT_18;
        end
        return p;
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // register bus
    logic [19:0] pat;
    logic [7:0]  feat;
    logic [7:0]  dec;
    logic [7:0]  mix;
    logic [7:0]  mix_prev;

    wire       [7:0] bus_idx   = paddr_in[9:2];
    wire             bus_align = (paddr_in[1:0] == 2'h0) && (paddr_in[DFC_AW-1:10] == '0);
    wire             setup     = psel_in && !penable_in;
    wire             wr_fire   = psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0];
    wire       [7:0] wbyte     = pwdata_in[7:0];
    logic            mapped;
    logic      [7:0] rd_byte;

    always_comb begin
        mapped  = bus_align;
        rd_byte = RST_BYTE;
        if (bus_idx == IDX_PAT_LO) begin
            rd_byte = pat[7:0];
        end else if (bus_idx == IDX_PAT_MID) begin
            rd_byte = pat[15:8];
        end else if (bus_idx == IDX_PAT_HI) begin
            rd_byte = {4'h0, pat[19:16]};
        end else if (bus_idx == IDX_FEAT) begin
            rd_byte = feat;
        end else if (bus_idx == IDX_DEC) begin
            rd_byte = dec;
        end else if (bus_idx == IDX_MIX) begin
            rd_byte = mix;
        end else begin
            mapped = 1'b0;
        end
    end

    // zero wait states: the answer is ready in the first access cycle
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            pready_out  <= 1'b0;
            prdata_out  <= 32'h00000000;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= setup;
            pslverr_out <= setup && !mapped;
            if (setup) begin
                prdata_out <= mapped ? {24'h000000, rd_byte} : 32'h00000000;
            end
        end
    end

    wire wr_ok = wr_fire && mapped;

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            pat  <= RST_PAT;
            feat <= RST_BYTE;
            dec  <= RST_BYTE;
            mix  <= RST_BYTE;
        end else if (wr_ok) begin
            if (bus_idx == IDX_PAT_LO) begin
                pat[7:0] <= wbyte;
            end else if (bus_idx == IDX_PAT_MID) begin
                pat[15:8] <= wbyte;
            end else if (bus_idx == IDX_PAT_HI) begin
                pat[19:16] <= wbyte[3:0] & PATHI_WMASK[3:0];
            end else if (bus_idx == IDX_FEAT) begin
                feat <= wbyte & FEAT_WMASK;
            end else if (bus_idx == IDX_DEC) begin
                dec <= wbyte & DEC_WMASK;
            end else if (bus_idx == IDX_MIX) begin
                mix <= wbyte & MIX_WMASK;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // configuration decode
    wire [1:0] route_sel  = feat[FEAT_ROUTE_L+1:FEAT_ROUTE_L];
    wire       path_on    = feat[FEAT_PATH];
    wire       dec_en     = feat[FEAT_DEC_EN];
    wire [2:0] ratio      = dec[DEC_RATIO_L+2:DEC_RATIO_L];
    wire       real_mode  = dec[DEC_REAL];
    // unused route codes feed channel a only
    wire       next_route_b = dec[DEC_ROUTE_EN] && (route_sel == ROUTE_A_B);
    wire       dec_active = path_on && dec_en;
    wire       bypassed   = !dec_active || (dfc_ratio_mask(ratio) == 5'h00);
    wire [19:0] next_pattern = bypassed ? dfc_auto_pattern(resolution_in) : pat;

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            frame_duty_pattern_out <= RST_PAT;
            route_to_b_out         <= 1'b0;
            decimator_enable_out   <= 1'b0;
            ratio_out              <= RATIO_BYPASS;
            real_mode_out          <= 1'b0;
            phase_invert_out       <= 1'b0;
            gain_a_out             <= GAIN_0DB;
            gain_b_out             <= GAIN_0DB;
            quarter_rate_mix_a_out <= 1'b0;
            quarter_rate_mix_b_out <= 1'b0;
        end else begin
            frame_duty_pattern_out <= next_pattern;
            route_to_b_out         <= next_route_b;
            decimator_enable_out   <= dec_active;
            ratio_out              <= ratio;
            real_mode_out          <= real_mode;
            phase_invert_out       <= dec[DEC_PHASE];
            gain_a_out             <= mix[MIX_GAIN_A_L+1:MIX_GAIN_A_L];
            gain_b_out             <= mix[MIX_GAIN_B_L+1:MIX_GAIN_B_L];
            quarter_rate_mix_a_out <= mix[MIX_QRM_A];
            quarter_rate_mix_b_out <= mix[MIX_QRM_B];
        end
    end

    // a restart is any change of the stored bit, either direction
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            mix_prev            <= RST_BYTE;
            mixer_restart_a_out <= 1'b0;
            mixer_restart_b_out <= 1'b0;
        end else begin
            mix_prev            <= mix;
            mixer_restart_a_out <= mix[MIX_RELOAD_A] ^ mix_prev[MIX_RELOAD_A];
            mixer_restart_b_out <= mix[MIX_RELOAD_B] ^ mix_prev[MIX_RELOAD_B];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // sample path
    logic [4:0] keep_cnt;
    wire        accept = sample_valid_in && sample_ready_out;
    wire  [4:0] keep_mask = dfc_ratio_mask(ratio);
    wire        keep   = !dec_active || (keep_cnt == keep_mask);
    wire        push   = accept && keep;

    // gain only compensates mixing loss, so it applies in complex mode only;
    // 3 dB is approximated as 1.375 to stay with shifts and adds
    wire signed [DFC_OW-1:0] raw  = DFC_OW'(signed'(sample_in));
    wire        [1:0]        gsel = mix[MIX_GAIN_A_L+1:MIX_GAIN_A_L];
    wire signed [DFC_OW-1:0] g3   = raw + (raw >>> 2) + (raw >>> 3);
    wire signed [DFC_OW-1:0] g6   = raw <<< 1;
    wire signed [DFC_OW-1:0] gained = (gsel == GAIN_3DB) ? g3 :
                                      (gsel == GAIN_6DB) ? g6 : raw;
    wire signed [DFC_OW-1:0] proc = (dec_active && !real_mode) ? gained : raw;
    wire        [DFC_WW-1:0] word = {next_route_b, proc};

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            keep_cnt <= 5'h00;
        end else if (!dec_active) begin
            keep_cnt <= 5'h00;
        end else if (accept) begin
            keep_cnt <= keep ? 5'h00 : 5'(keep_cnt + 5'h01);
        end
    end

    // two-entry skid buffer: output stage plus one spare
    logic [DFC_WW-1:0] spare;
    logic              spare_valid;
    wire               out_load = !word_valid_out || word_ready_in;
    wire               next_spare_valid = out_load ? 1'b0 : (spare_valid || push);

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            word_out         <= '0;
            word_valid_out   <= 1'b0;
            spare            <= '0;
            spare_valid      <= 1'b0;
            sample_ready_out <= 1'b0;
        end else begin
            spare_valid      <= next_spare_valid;
            sample_ready_out <= !next_spare_valid;
            if (out_load) begin
                if (spare_valid) begin
                    word_out       <= spare;
                    word_valid_out <= 1'b1;
                end else begin
                    word_out       <= word;
                    word_valid_out <= push;
                end
            end else if (push) begin
                spare <= word;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    a_pattern_auto: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        // the edge that releases reset still loads the reset pattern
        rst_b_in && bypassed |=> frame_duty_pattern_out == dfc_auto_pattern($past(resolution_in)))
        else $error("frame pattern not automatic in bypass");

    a_pattern_prog: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        !bypassed |=> frame_duty_pattern_out == $past(pat))
        else $error("frame pattern not the programmed one");

    a_pattern_write: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        wr_ok && bus_idx == IDX_PAT_MID |=> pat[15:8] == $past(wbyte))
        else $error("pattern middle byte not written");

    a_route_gate: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        !dec[DEC_ROUTE_EN] |=> !route_to_b_out)
        else $error("route to b while routing disabled");

    a_route_both: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        dec[DEC_ROUTE_EN] && route_sel == ROUTE_A_B |=> route_to_b_out)
        else $error("route code 01 did not reach b");

    a_bypass_raw: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        !path_on && push && out_load && !spare_valid |=> word_out[DFC_OW-1:0] == $past(raw))
        else $error("bypassed sample altered");

    a_dec_enable: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        decimator_enable_out |-> $past(path_on) && $past(dec_en))
        else $error("decimator on without enable");

    a_ratio_two: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        dec_active && ratio == 3'h1 && accept && keep |-> ##1 !(accept && keep))
        else $error("decimate by two kept consecutive samples");

    a_real_nogain: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        real_mode && push && out_load && !spare_valid |=> word_out[DFC_OW-1:0] == $past(raw))
        else $error("gain applied in real mode");

    a_restart_pulse: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        $changed(mix[MIX_RELOAD_A]) |=> mixer_restart_a_out ##1 !mixer_restart_a_out || $changed(mix[MIX_RELOAD_A]))
        else $error("restart a not a single pulse");

    a_phase_follow: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        ##1 phase_invert_out == $past(dec[DEC_PHASE]))
        else $error("phase invert does not follow register");

    a_buffer_hold: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
        word_valid_out && !word_ready_in |=> word_valid_out && $stable(word_out))
        else $error("stalled word changed");
endmodule
`default_nettype wire

//--- tb/dfc_rx_model.sv
// receiver model for the processed sample stream
`timescale 1ns/1ps
`default_nettype none
module dfc_rx_model (
    // clock and reset
    input  wire logic                      clk_sys_in,
    input  wire logic                      rst_b_in,
    // stream from the block
    input  wire logic [dfc_pkg::DFC_WW-1:0] word_in,
    input  wire logic                      word_valid_in,
    output logic                           word_ready_out,
    // 0 always ready, 1 random stalls, 2 stalled
    input  wire logic [1:0]                stall_mode_in
);
    import dfc_pkg::*;
    logic [DFC_WW-1:0] got_q[$];
    logic [DFC_WW-1:0] last_word;
    logic              pending;
    int                hold_err;
    int                seed;
    initial begin
        seed = 84;
        hold_err = 0;
    end
    always @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            word_ready_out <= 1'b0;
            pending <= 1'b0;
        end else begin
            if (word_valid_in && word_ready_out)
                got_q.push_back(word_in);
            // a word offered but not taken must stay on the lines
            if (pending && !(word_valid_in === 1'b1 && word_in === last_word))
                hold_err++;
            pending <= word_valid_in && !word_ready_out;
            last_word <= word_in;
            word_ready_out <= (stall_mode_in == 2'd0) || (stall_mode_in == 2'd1 && $random(seed) % 2 == 0);
        end
    end
endmodule
`default_nettype wire

//--- tb/ddc_frame_config_tb.sv
// self-checking bench for the downconverter and frame configuration block
`timescale 1ns/1ps
`default_nettype none
module ddc_frame_config_tb;
    import dfc_pkg::*;
    logic        clk, rst_b, psel, pen, pwr, prdy, perr, sv, sr, wv, wr_rdy, rb, de, rm, pi, qa, qb, ra, rbs, err;
    logic [11:0] paddr;
    logic [31:0] pwd, prd, rd;
    logic [3:0]  pstrb;
    logic [13:0] smp;
    logic [1:0]  res, stall, ga, gb;
    logic [18:0] word;
    logic [19:0] pat;
    logic [2:0]  ratio;
    logic [18:0] exp_q[$];
    logic [7:0]  idx_tbl[6] = '{IDX_PAT_LO, IDX_PAT_MID, IDX_PAT_HI, IDX_FEAT, IDX_DEC, IDX_MIX};
    logic [7:0]  msk_tbl[6] = '{8'hff, 8'hff, PATHI_WMASK, FEAT_WMASK, DEC_WMASK, MIX_WMASK};
    logic [19:0] pat_tbl[4] = '{AUTO_PAT_14, AUTO_PAT_16, AUTO_PAT_18, AUTO_PAT_20};
    logic [7:0]  mix_tbl[3] = '{8'h20, 8'h22, 8'h00};
    int          err_total, checks_done, seed, na, nb, ca, cb;
    dfc_top i_dut (.clk_sys_in(clk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(paddr), .pwdata_in(pwd), .pstrb_in(pstrb), .pready_out(prdy), .prdata_out(prd),
        .pslverr_out(perr), .sample_in(smp), .sample_valid_in(sv), .sample_ready_out(sr),
        .resolution_in(res), .word_out(word), .word_valid_out(wv), .word_ready_in(wr_rdy),
        .frame_duty_pattern_out(pat), .route_to_b_out(rb), .decimator_enable_out(de), .ratio_out(ratio),
        .real_mode_out(rm), .phase_invert_out(pi), .gain_a_out(ga), .gain_b_out(gb),
        .quarter_rate_mix_a_out(qa), .quarter_rate_mix_b_out(qb), .mixer_restart_a_out(ra),
        .mixer_restart_b_out(rbs));
    dfc_rx_model i_rx (.clk_sys_in(clk), .rst_b_in(rst_b), .word_in(word), .word_valid_in(wv),
        .word_ready_out(wr_rdy), .stall_mode_in(stall));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        na <= na + int'(ra === 1'b1);
        nb <= nb + int'(rbs === 1'b1);
    end
    //////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (prdy !== 1'b1 && n < 20);
        if (n >= 20) begin err_total++; give_verdict(); end
        rd = prd;
        err = perr;
        psel <= 1'b0; pen <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] v);
        apb(1'b1, {2'b00, i, 2'b00}, {24'h0, v});
    endtask
    task automatic rdchk(input logic [7:0] i, input logic [7:0] v);
        apb(1'b0, {2'b00, i, 2'b00}, 32'h0);
        chk(rd, {24'h0, v});
        chk(32'(err), 32'h0);
    endtask
    task automatic wpat(input logic [19:0] v);
        wr(IDX_PAT_LO, v[7:0]); wr(IDX_PAT_MID, v[15:8]); wr(IDX_PAT_HI, {4'h0, v[19:16]});
    endtask
    task automatic reset_dut();
        rst_b <= 1'b0;
        tick(3);
        rst_b <= 1'b1;
        tick(1);
    endtask
    task automatic send(input logic [13:0] x);
        int n;
        smp <= x; sv <= 1'b1;
        n = 0;
        do begin @(posedge clk); n++; end while (sr !== 1'b1 && n < 100);
        if (n >= 100) begin err_total++; give_verdict(); end
    endtask
    function automatic logic [18:0] expw(input logic b, input logic [13:0] x, input logic [1:0] g);
        logic signed [17:0] s;
        s = 18'(signed'(x));
        if (g == GAIN_6DB) s = s <<< 1;
        else if (g == GAIN_3DB) s = s + (s >>> 2) + (s >>> 3);
        return {b, s};
    endfunction
    // drain the receiver and compare everything it took against the expected words
    task automatic drain();
        int k;
        sv <= 1'b0;
        k = 0;
        while (i_rx.got_q.size() < exp_q.size() && k < 300) begin @(posedge clk); k++; end
        tick(6);
        chk(i_rx.got_q.size(), exp_q.size());
        foreach (exp_q[j]) if (j < i_rx.got_q.size()) chk(i_rx.got_q[j], exp_q[j]);
        chk(i_rx.hold_err, 0);
        exp_q.delete();
        i_rx.got_q.delete();
    endtask
    task automatic stream(input int n, input int p, input logic b, input logic [1:0] g);
        logic [13:0] x;
        stall <= 2'd1;
        for (int i = 0; i < n; i++) begin
            x = (i == 0) ? 14'h2000 : (i == 1) ? 14'h1fff : 14'($random(seed));
            send(x);
            if ((i + 1) % p == 0) exp_q.push_back(expw(b, x, g));
        end
        drain();
    endtask
    //////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 84; err_total = 0; checks_done = 0; na = 0; nb = 0;
        psel = 0; pen = 0; pwr = 0; paddr = 0; pwd = 0; pstrb = 4'hf;
        smp = 0; sv = 0; res = 0; stall = 0; rst_b = 0;
        reset_dut();
        foreach (idx_tbl[i]) rdchk(idx_tbl[i], 8'h00);
        foreach (idx_tbl[i]) apb(1'b1, {2'b00, idx_tbl[i], 2'b00}, 32'hffffffff);
        foreach (idx_tbl[i]) rdchk(idx_tbl[i], msk_tbl[i]);
        tick(3);
        chk(32'({rb, de, ratio, rm, pi, ga, gb, qa, qb}), 32'h00000fff);
        chk(32'(pat), 32'(AUTO_PAT_14));
        apb(1'b0, 12'h08c, 32'h0);
        chk(rd, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b0, 12'h095, 32'h0); chk(32'(err), 32'h1);
        apb(1'b1, 12'h494, 32'h0); chk(32'(err), 32'h1);
        pstrb <= 4'h0; wr(IDX_MIX, 8'h00); pstrb <= 4'hf;
        rdchk(IDX_MIX, 8'hff); rdchk(IDX_DEC, 8'hf9);
        // routing only acts once the route enable bit is set
        reset_dut();
        wr(IDX_FEAT, 8'h08); tick(2); chk(32'(rb), 32'h0);
        wr(IDX_DEC, 8'h80); tick(2); chk(32'(rb), 32'h1);
        stream(10, 1, 1'b1, GAIN_0DB);
        // fill the two-entry buffer against a stalled receiver
        stall <= 2'd2; tick(2);
        send(14'h0123); send(14'h3abc);
        smp <= 14'h0042;
        repeat (3) begin @(posedge clk); chk(32'(sr), 32'h0); end
        stall <= 2'd0; send(14'h0042);
        exp_q = '{expw(1'b1, 14'h0123, GAIN_0DB), expw(1'b1, 14'h3abc, GAIN_0DB), expw(1'b1, 14'h0042, GAIN_0DB)};
        drain();
        for (int r = 1; r <= 5; r++) begin
            reset_dut();
            // real mode; this block holds no frequency word to zero
            wr(IDX_DEC, {1'b0, 3'(r), 4'h8}); wr(IDX_FEAT, 8'h06); tick(3);
            stream(2 << r, 1 << r, 1'b0, GAIN_0DB);
        end
        reset_dut();
        wr(IDX_MIX, 8'h80); wr(IDX_DEC, 8'h10); wr(IDX_FEAT, 8'h06); tick(3);
        stream(8, 2, 1'b0, GAIN_6DB);
        wr(IDX_MIX, 8'h40); tick(3);
        stream(8, 2, 1'b0, GAIN_3DB);
        reset_dut();
        for (int r = 0; r < 4; r++) begin res <= 2'(r); tick(4); chk(pat, pat_tbl[r]); end
        wr(IDX_DEC, 8'h18); wr(IDX_FEAT, 8'h06);
        for (int r = 0; r < 4; r++) begin
            res <= 2'(r); wpat(pat_tbl[r]); tick(3); chk(pat, pat_tbl[r]);
        end
        wr(IDX_DEC, 8'h10); wpat(20'hfffff); tick(3); chk(pat, 20'hfffff);
        wr(IDX_DEC, 8'h60); tick(3); chk(pat, AUTO_PAT_20);
        for (int r = 0; r < 6; r++) begin
            wr(IDX_DEC, {1'b0, 3'(r), r[0], 2'b00, ~r[0]}); tick(2);
            chk({ratio, rm, pi}, {3'(r), r[0], ~r[0]});
        end
        for (int k = 1; k < 4; k++) begin wr(IDX_FEAT, 8'(k << 1)); tick(2); chk(32'(de), 32'(k == 3)); end
        for (int g = 0; g < 3; g++) begin
            wr(IDX_MIX, {2'(g), 1'b0, g[0], 2'(2 - g), 1'b0, ~g[0]}); tick(2);
            chk({ga, qa, gb, qb}, {2'(g), g[0], 2'(2 - g), ~g[0]});
        end
        foreach (mix_tbl[i]) begin
            ca = na; cb = nb;
            wr(IDX_MIX, mix_tbl[i]); tick(5);
            chk({16'(na - ca), 16'(nb - cb)}, {16'(i != 1), 16'(i != 0)});
            rdchk(IDX_MIX, mix_tbl[i]);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
